/* hw/thermal_cfg_pkg.sv */
package thermal_cfg_pkg;

	// Register placement and power-on value
	localparam logic [7:0] CFG_OFFSET = 8'h7c;
	localparam logic [7:0] CFG_RESET  = 8'h01;

	// Field positions inside the configuration register
	localparam int SIGNED_BIT        = 0;
	localparam int OFFSET_SCALE_BIT  = 1;
	localparam int CPU_EN_BIT        = 4;
	localparam int REMOTE1_EN_BIT    = 5;
	localparam int LOCAL_EN_BIT      = 6;
	localparam int REMOTE2_EN_BIT    = 7;

	// Source numbering, which is also the order of the enable bits
	localparam int NUM_SRC     = 4;
	localparam int SRC_CPU     = 0;
	localparam int SRC_REMOTE1 = 1;
	localparam int SRC_LOCAL   = 2;
	localparam int SRC_REMOTE2 = 3;

	// Limit codes that switch a source off in each number format
	localparam logic [7:0] DISABLE_OFFSET64 = 8'h00;
	localparam logic [7:0] DISABLE_TWOS     = 8'h80;

	// Bias of the offset-64 format
	localparam logic signed [8:0] OFFSET64_BIAS = 9'h040;

	// Assertion timer resolution
	localparam int TICK_US     = 22760;
	localparam int CLK_MHZ     = 125;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

	// Width of the assertion length count in ticks
	localparam int TICKS_W = 9;

endpackage

/* hw/overtemp_timer.sv */
`timescale 1ns/1ns
// Measures how long the overtemperature pin stays asserted and flags
// overlong assertions in a sticky status bit.
module overtemp_timer #(
	parameter int TICK_CYC = thermal_cfg_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	// Pin level, already synchronised, high while asserted
	input  wire logic       asserted_in,
	// Allowed assertion length in ticks
	input  wire logic [7:0] limit_in,
	// Status clear strobe from the status register read
	input  wire logic       clear_in,
	// Sticky overtemperature status
	output logic            status_out
);
	import thermal_cfg_pkg::*;

	localparam int PW = $clog2(TICK_CYC + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);
	localparam logic [TICKS_W-1:0] TICKS_MAX = '1;

	logic [PW-1:0]      prescale_q, prescale_d;
	logic [TICKS_W-1:0] ticks_q, ticks_d;
	logic               status_q, status_d;
	logic               fire;

	////////////////////////////////////////////////////////////////
	// Tick counting; the count saturates so a stuck pin cannot wrap
	// back under the limit and hide itself
	always_comb begin
		prescale_d = '0;
		ticks_d    = '0;
		if (asserted_in) begin
			prescale_d = (prescale_q == PRE_LAST) ? '0 : prescale_q + 1'b1;
			ticks_d    = ticks_q;
			if (prescale_q == PRE_LAST && ticks_q != TICKS_MAX) begin
				ticks_d = ticks_q + 1'b1;
			end
		end
		// A zero limit fires on the first asserted cycle
		fire     = asserted_in && (ticks_q >= {1'b0, limit_in}); // R14
		// Set wins over a clear in the same cycle
		status_d = fire | (status_q & ~clear_in); // R14
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			prescale_q <= '0;
			ticks_q    <= '0;
			status_q   <= 1'b0;
		end else begin
			prescale_q <= prescale_d;
			ticks_q    <= ticks_d;
			status_q   <= status_d;
		end
	end

	assign status_out = status_q;

endmodule // overtemp_timer

/* hw/thermal_format_config.sv */
`timescale 1ns/1ns
// Overview of operation
// R1: After reset the configuration register holds 0x01, twos complement selected.
// R2: Bit 0 picks the number format: one twos complement, zero offset-64.
// R3: Limits and readings are compared in whichever format is currently selected.
// R4: Bit 1 picks offset steps: zero half degree, one whole degree.
// R5: Offset scaling touches remote 1, local, remote 2; CPU offset stays whole degree.
// R6: Bit 4 lets CPU reading above its control limit drive the pin.
// R7: Bit 5 lets remote 1 above its limit drive the pin.
// R8: Bit 6 lets local above its limit drive the pin.
// R9: Bit 7 lets remote 2 above its limit drive the pin.
// R10: A cleared enable never drives the pin; pin then only feeds the timer.
// R11: A limit of -64 (offset-64) or -128 (twos) disables that source.
// R12: Software should set the timer limit to 0xFF when the pin drives.
// R13: With the lock bit set, writes to this register are ignored.
// R14: Pin asserted longer than the timer limit sets the overtemperature status.
// R15: Pin drive is the OR of the four qualified source conditions.
module thermal_format_config #(
	parameter int TICK_CYC = thermal_cfg_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	// Register access from the serial interface
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       lock_in,
	output logic      [7:0] reg_rdata_out,
	output logic            reg_rvalid_out,
	// Pin function: high when the pin works both ways
	input  wire logic       pin_bidir_in,
	// Temperature readings
	input  wire logic [7:0] cpu_temp_in,
	input  wire logic [7:0] remote1_temp_in,
	input  wire logic [7:0] local_temp_in,
	input  wire logic [7:0] remote2_temp_in,
	// Overtemperature limits
	input  wire logic [7:0] cpu_control_limit_in,
	input  wire logic [7:0] remote1_limit_in,
	input  wire logic [7:0] local_limit_in,
	input  wire logic [7:0] remote2_limit_in,
	// Sensor offset codes
	input  wire logic [7:0] cpu_offset_in,
	input  wire logic [7:0] remote1_offset_in,
	input  wire logic [7:0] local_offset_in,
	input  wire logic [7:0] remote2_offset_in,
	// Offsets in half-degree units
	output logic      [9:0] cpu_offset_half_out,
	output logic      [9:0] remote1_offset_half_out,
	output logic      [9:0] local_offset_half_out,
	output logic      [9:0] remote2_offset_half_out,
	// Format seen by the rest of the device
	output logic            signed_range_select_out,
	// Assertion timer
	input  wire logic [7:0] timer_limit_in,
	input  wire logic       status_clear_in,
	output logic            overtemp_status_out,
	// Open-drain overtemperature pin, active low
	input  wire logic       overtemp_pin_in,
	output logic            overtemp_pin_out,
	output logic            overtemp_pin_oe_out
);
	import thermal_cfg_pkg::*;

	////////////////////////////////////////////////////////////////
	// Helpers

	// Bring a code onto a common signed scale for the current format
	function automatic logic signed [8:0] to_signed(input logic [7:0] code,
		input logic twos);
		if (twos) begin
			to_signed = $signed({code[7], code});
		end else begin
			to_signed = $signed({1'b0, code}) - OFFSET64_BIAS;
		end
	endfunction

	// Offset code to half-degree units
	function automatic logic [9:0] to_half(input logic [7:0] code,
		input logic whole);
		if (whole) begin
			to_half = {code[7], code, 1'b0};
		end else begin
			to_half = {{2{code[7]}}, code};
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Configuration register

	logic [7:0] cfg_q, cfg_d;
	logic [7:0] rdata_q, rdata_d;
	logic       rvalid_q, rvalid_d;
	logic       wr_hit;

	always_comb begin
		wr_hit   = reg_wr_in && (reg_addr_in == CFG_OFFSET);
		cfg_d    = cfg_q;
		// A locked register silently drops writes
		if (wr_hit && !lock_in) begin // R13
			cfg_d = reg_wdata_in;
		end
		// Reserved bits read back as written; other addresses belong elsewhere
		rdata_d  = (reg_addr_in == CFG_OFFSET) ? cfg_q : 8'h00;
		rvalid_d = reg_rd_in;
		if (!reg_rd_in) begin
			rdata_d = rdata_q;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q    <= CFG_RESET; // R1
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			cfg_q    <= cfg_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign reg_rdata_out  = rdata_q;
	assign reg_rvalid_out = rvalid_q;

	////////////////////////////////////////////////////////////////
	// Per-source overtemperature conditions

	logic [7:0]         temp_v  [NUM_SRC];
	logic [7:0]         limit_v [NUM_SRC];
	logic [NUM_SRC-1:0] src_hot;
	logic [7:0]         off_code;

	assign temp_v[SRC_CPU]      = cpu_temp_in;
	assign temp_v[SRC_REMOTE1]  = remote1_temp_in;
	assign temp_v[SRC_LOCAL]    = local_temp_in;
	assign temp_v[SRC_REMOTE2]  = remote2_temp_in;
	assign limit_v[SRC_CPU]     = cpu_control_limit_in;
	assign limit_v[SRC_REMOTE1] = remote1_limit_in;
	assign limit_v[SRC_LOCAL]   = local_limit_in;
	assign limit_v[SRC_REMOTE2] = remote2_limit_in;
	assign off_code = cfg_q[SIGNED_BIT] ? DISABLE_TWOS : DISABLE_OFFSET64;

	// Each source needs its enable, a live limit and a reading above it
	for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
		assign src_hot[s] = cfg_q[CPU_EN_BIT + s] // R6 R7 R8 R9 R10
			&& (limit_v[s] != off_code) // R11
			&& (to_signed(temp_v[s], cfg_q[SIGNED_BIT])
				> to_signed(limit_v[s], cfg_q[SIGNED_BIT])); // R3
	end

	////////////////////////////////////////////////////////////////
	// Pin drive and input synchroniser

	logic drive_q, drive_d;
	logic pin_low_q;
	logic sync1_q, sync2_q;

	// Only a bidirectional pin may be pulled; otherwise it stays an input
	always_comb begin
		drive_d = pin_bidir_in && (|src_hot); // R15
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			drive_q   <= 1'b0;
			pin_low_q <= 1'b0;
			sync1_q   <= 1'b1;
			sync2_q   <= 1'b1;
		end else begin
			drive_q   <= drive_d;
			pin_low_q <= 1'b0;
			sync1_q   <= overtemp_pin_in;
			sync2_q   <= sync1_q;
		end
	end

	assign overtemp_pin_out    = pin_low_q;
	assign overtemp_pin_oe_out = drive_q;

	// The timer sees our own drive too, through the wire level
	overtemp_timer #(
		.TICK_CYC (TICK_CYC)
	) u_timer (
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.asserted_in (~sync2_q), // R10 R14
		.limit_in    (timer_limit_in),
		.clear_in    (status_clear_in),
		.status_out  (overtemp_status_out)
	);

	////////////////////////////////////////////////////////////////
	// Format and offset scaling outputs

	logic       fmt_q, fmt_d;
	logic [9:0] off_q [NUM_SRC];
	logic [9:0] off_d [NUM_SRC];

	// CPU offset is fixed at whole degrees; the others follow bit 1
	always_comb begin
		fmt_d              = cfg_q[SIGNED_BIT]; // R2
		off_d[SRC_CPU]     = to_half(cpu_offset_in, 1'b1); // R5
		off_d[SRC_REMOTE1] = to_half(remote1_offset_in, cfg_q[OFFSET_SCALE_BIT]); // R4
		off_d[SRC_LOCAL]   = to_half(local_offset_in, cfg_q[OFFSET_SCALE_BIT]);
		off_d[SRC_REMOTE2] = to_half(remote2_offset_in, cfg_q[OFFSET_SCALE_BIT]);
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			fmt_q <= CFG_RESET[SIGNED_BIT];
			for (int i = 0; i < NUM_SRC; i++) begin
				off_q[i] <= 10'h000;
			end
		end else begin
			fmt_q <= fmt_d;
			for (int i = 0; i < NUM_SRC; i++) begin
				off_q[i] <= off_d[i];
			end
		end
	end

	assign signed_range_select_out = fmt_q;
	assign cpu_offset_half_out     = off_q[SRC_CPU];
	assign remote1_offset_half_out = off_q[SRC_REMOTE1];
	assign local_offset_half_out   = off_q[SRC_LOCAL];
	assign remote2_offset_half_out = off_q[SRC_REMOTE2];

	////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	a_reset_value: assert property ($fell(rst_in) |-> cfg_q == 8'h01) // R1
		else $error("config not 0x01 after reset");

	a_format_follow: assert property (
		reg_wr_in && !lock_in && reg_addr_in == CFG_OFFSET
		|=> ##1 signed_range_select_out == $past(reg_wdata_in[0], 2)) // R2
		else $error("format output did not follow write");

	a_write_locked: assert property (
		reg_wr_in && lock_in |=> $stable(cfg_q)) // R13
		else $error("locked register changed");

	a_cpu_twos_drive: assert property (
		cfg_q[4] && cfg_q[0] && pin_bidir_in && cpu_control_limit_in != 8'h80
		&& $signed(cpu_temp_in) > $signed(cpu_control_limit_in)
		|=> overtemp_pin_oe_out && !overtemp_pin_out) // R6 R3
		else $error("cpu overtemperature not driven");

	a_remote1_off64: assert property (
		cfg_q[5] && !cfg_q[0] && pin_bidir_in && remote1_limit_in != 8'h00
		&& remote1_temp_in > remote1_limit_in |=> overtemp_pin_oe_out) // R7 R3
		else $error("remote 1 overtemperature not driven");

	a_local_drive: assert property (
		cfg_q[6] && cfg_q[0] && pin_bidir_in && local_limit_in != 8'h80
		&& $signed(local_temp_in) > $signed(local_limit_in)
		|=> overtemp_pin_oe_out) // R8
		else $error("local overtemperature not driven");

	a_remote2_drive: assert property (
		cfg_q[7] && !cfg_q[0] && pin_bidir_in && remote2_limit_in != 8'h00
		&& remote2_temp_in > remote2_limit_in |=> overtemp_pin_oe_out) // R9
		else $error("remote 2 overtemperature not driven");

	a_disabled_quiet: assert property (
		(cfg_q[7:4] == 4'h0 || !pin_bidir_in) |=> !overtemp_pin_oe_out) // R10
		else $error("pin driven with no enabled source");

	a_limit_disable: assert property (
		cfg_q[0] && cpu_control_limit_in == 8'h80 && remote1_limit_in == 8'h80
		&& local_limit_in == 8'h80 && remote2_limit_in == 8'h80
		|=> !overtemp_pin_oe_out) // R11
		else $error("disabled limit still drives pin");

	a_cpu_offset_whole: assert property (
		1'b1 |=> cpu_offset_half_out == {$past(cpu_offset_in[7]),
			$past(cpu_offset_in), 1'b0}) // R5
		else $error("cpu offset not whole degrees");

	a_offset_scale: assert property (
		!cfg_q[1] && remote1_offset_in == 8'hff
		|=> remote1_offset_half_out == 10'h3ff) // R4
		else $error("half degree offset scaled wrong");

	sequence s_pin_held;
		!sync2_q && timer_limit_in == 8'h00 && !status_clear_in;
	endsequence

	// The second step only holds when no clear arrives in between
	a_status_set: assert property (
		s_pin_held |=> overtemp_status_out
			and (!status_clear_in |=> overtemp_status_out)) // R14
		else $error("overtemperature status not set");

endmodule // thermal_format_config

/* bench/thermal_format_config_tb.sv */
`timescale 1ns/1ns
module thermal_format_config_tb;
	import thermal_cfg_pkg::*;

	// Short tick so the assertion timer trips within a few dozen cycles
	localparam int TICKS = 4;
	localparam logic [9:0] HALF0 [4] = '{10'h00a, 10'h3ff, 10'h003, 10'h381};
	localparam logic [9:0] HALF1 [4] = '{10'h00a, 10'h3fe, 10'h006, 10'h302};

	logic       clock_in = 1'b0;
	logic       rst_in   = 1'b1;
	logic       wr = 1'b0, rd = 1'b0, lock = 1'b0, bidir = 1'b1, ext_low = 1'b0, clr = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, tlim = 8'hff;
	logic [7:0] temp [4];
	logic [7:0] lim [4];
	logic [7:0] off [4];
	logic [9:0] half [4];
	logic [7:0] rdata;
	logic       rvalid, ssel, status, pin_out, pin_oe;
	int         n_mismatch = 0;
	int         checks_done = 0;
	int         i;

	// Open-drain wire with pull-up: low while either party pulls
	wire pin_wire = !(pin_oe || ext_low);

	always #4 clock_in = ~clock_in;

	thermal_format_config #(.TICK_CYC(TICKS)) u_dut (
		.clock_in(clock_in), .rst_in(rst_in),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.lock_in(lock), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.pin_bidir_in(bidir),
		.cpu_temp_in(temp[0]), .remote1_temp_in(temp[1]),
		.local_temp_in(temp[2]), .remote2_temp_in(temp[3]),
		.cpu_control_limit_in(lim[0]), .remote1_limit_in(lim[1]),
		.local_limit_in(lim[2]), .remote2_limit_in(lim[3]),
		.cpu_offset_in(off[0]), .remote1_offset_in(off[1]),
		.local_offset_in(off[2]), .remote2_offset_in(off[3]),
		.cpu_offset_half_out(half[0]), .remote1_offset_half_out(half[1]),
		.local_offset_half_out(half[2]), .remote2_offset_half_out(half[3]),
		.signed_range_select_out(ssel),
		.timer_limit_in(tlim), .status_clear_in(clr), .overtemp_status_out(status),
		.overtemp_pin_in(pin_wire), .overtemp_pin_out(pin_out), .overtemp_pin_oe_out(pin_oe)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Comparison and closing
	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Register access: one-cycle strobes, read answer one cycle later
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock_in);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string name);
		int k;
		@(posedge clock_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock_in);
		rd <= 1'b0;
		#1;
		for (k = 0; k < 4 && rvalid !== 1'b1; k++) begin
			@(posedge clock_in);
			#1;
		end
		chk("read valid", 10'h001, {9'h000, rvalid});
		if (rvalid !== 1'b1) begin
			conclude();
		end
		chk(name, {2'b00, exp}, {2'b00, rdata});
	endtask

	// Pin drive is registered, so let inputs and config land first
	task automatic settle();
		repeat (3) @(posedge clock_in);
		#1;
	endtask

	task automatic pin(input logic e, input string name);
		settle();
		chk(name, {9'h000, e}, {9'h000, pin_oe});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		for (int s = 0; s < 4; s++) begin
			temp[s] = 8'h30;
			lim[s] = 8'h40;
			off[s] = 8'h00;
		end
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		#1;
		chk("range select at reset", 10'h001, {9'h000, ssel});
		rd_reg(CFG_OFFSET, CFG_RESET, "config reset");
		wr_reg(CFG_OFFSET, 8'h0c);
		rd_reg(CFG_OFFSET, 8'h0c, "config readback");
		chk("range select", 10'h000, {9'h000, ssel});
		@(posedge clock_in);
		lock <= 1'b1;
		wr_reg(CFG_OFFSET, 8'hf3);
		rd_reg(CFG_OFFSET, 8'h0c, "locked config");
		chk("locked range select", 10'h000, {9'h000, ssel});
		@(posedge clock_in);
		lock <= 1'b0;
		wr_reg(8'h7b, 8'haa);
		rd_reg(CFG_OFFSET, 8'h0c, "other address write");
		rd_reg(8'h7b, 8'h00, "unmapped read");
		// Offset scaling: half-degree steps, then whole-degree steps
		@(posedge clock_in);
		off[0] <= 8'h05;
		off[1] <= 8'hff;
		off[2] <= 8'h03;
		off[3] <= 8'h81;
		settle();
		for (int s = 0; s < 4; s++) chk("offset half step", HALF0[s], half[s]);
		wr_reg(CFG_OFFSET, 8'h0f);
		settle();
		for (int s = 0; s < 4; s++) chk("offset whole step", HALF1[s], half[s]);
		// Each source alone; timer limit kept at maximum while driving
		@(posedge clock_in);
		tlim <= 8'hff;
		for (int s = 0; s < 4; s++) begin
			@(posedge clock_in);
			temp[s] <= 8'h50;
			wr_reg(CFG_OFFSET, 8'(8'h01 | (8'h10 << s)));
			pin(1'b1, "source drive");
			wr_reg(CFG_OFFSET, 8'(8'hf1 & ~(8'h10 << s)));
			pin(1'b0, "disabled source");
			@(posedge clock_in);
			lim[s] <= 8'h80;
			wr_reg(CFG_OFFSET, 8'hf1);
			pin(1'b0, "disable limit twos");
			@(posedge clock_in);
			lim[s] <= 8'h40;
			temp[s] <= 8'h40;
			pin(1'b0, "equal to limit");
			@(posedge clock_in);
			temp[s] <= 8'h30;
		end
		chk("pin output level", 10'h000, {9'h000, pin_out});
		// Format switch reinterprets the same codes
		@(posedge clock_in);
		temp[0] <= 8'h90;
		pin(1'b0, "negative in twos");
		wr_reg(CFG_OFFSET, 8'hf0);
		pin(1'b1, "above in offset64");
		@(posedge clock_in);
		bidir <= 1'b0;
		pin(1'b0, "pin not bidirectional");
		@(posedge clock_in);
		bidir <= 1'b1;
		lim[0] <= 8'h00;
		pin(1'b0, "disable limit offset64");
		@(posedge clock_in);
		lim[0] <= 8'h80;
		pin(1'b1, "plain limit offset64");
		// Remote sources in offset-64, where only the unsigned compare trips
		@(posedge clock_in);
		temp[0] <= 8'h30;
		lim[0] <= 8'h40;
		temp[1] <= 8'h90;
		pin(1'b1, "remote 1 offset64");
		@(posedge clock_in);
		temp[1] <= 8'h30;
		temp[3] <= 8'h90;
		pin(1'b1, "remote 2 offset64");
		// Every limit at the twos disable code silences even hot readings
		@(posedge clock_in);
		for (int s = 0; s < 4; s++) begin
			lim[s] <= 8'h80;
			temp[s] <= 8'h50;
		end
		wr_reg(CFG_OFFSET, 8'hf1);
		pin(1'b0, "all limits disabled");
		@(posedge clock_in);
		for (int s = 0; s < 4; s++) begin
			lim[s] <= 8'h40;
			temp[s] <= 8'h30;
		end
		wr_reg(CFG_OFFSET, 8'h01);
		// Assertion timer: two ticks allowed, then sticky until cleared
		@(posedge clock_in);
		tlim <= 8'h02;
		ext_low <= 1'b1;
		settle();
		chk("status early", 10'h000, {9'h000, status});
		for (i = 0; i < 60 && status !== 1'b1; i++) begin
			@(posedge clock_in);
			#1;
		end
		chk("status after limit", 10'h001, {9'h000, status});
		if (status !== 1'b1) begin
			conclude();
		end
		@(posedge clock_in);
		ext_low <= 1'b0;
		settle();
		chk("status sticky", 10'h001, {9'h000, status});
		@(posedge clock_in);
		clr <= 1'b1;
		@(posedge clock_in);
		clr <= 1'b0;
		tlim <= 8'h00;
		settle();
		chk("status cleared", 10'h000, {9'h000, status});
		@(posedge clock_in);
		ext_low <= 1'b1;
		settle();
		chk("status zero limit", 10'h001, {9'h000, status});
		conclude();
	end
endmodule // thermal_format_config_tb
